// ### common/cix_pkg.sv
package cix_pkg;

  // apb byte addresses
  localparam logic [11:0] CIX_CMD_ADDR    = 12'h000;
  localparam logic [11:0] CIX_ACC_ADDR    = 12'h004;
  localparam logic [11:0] CIX_STAT_ADDR   = 12'h008;
  localparam logic [11:0] CIX_DIRA_ADDR   = 12'h00c;
  localparam logic [11:0] CIX_DIRB_ADDR   = 12'h010;
  localparam logic [11:0] CIX_DIRC_ADDR   = 12'h014;
  localparam logic [11:0] CIX_WDOG_ADDR   = 12'h018;
  localparam logic [11:0] CIX_FILE_BASE   = 12'h200;
  localparam logic [11:0] CIX_FILE_MASK   = 12'he00;

  // status bit positions
  localparam int CIX_ST_C     = 0;
  localparam int CIX_ST_DC    = 1;
  localparam int CIX_ST_Z     = 2;
  localparam int CIX_ST_PD    = 3;
  localparam int CIX_ST_TO    = 4;
  localparam int CIX_ST_SLEEP = 5;
  localparam int CIX_ST_BUSY  = 6;

  // operand values of the direction load
  localparam logic [6:0] CIX_DIR_SEL_A = 7'h05;
  localparam logic [6:0] CIX_DIR_SEL_B = 7'h06;
  localparam logic [6:0] CIX_DIR_SEL_C = 7'h07;

  // reset values, watchdog prescale and file depth
  localparam logic [7:0] CIX_DIR_RST   = 8'hff;
  localparam logic [7:0] CIX_WDOG_ZERO = 8'h00;
  localparam int         CIX_WDOG_PRE  = 16;
  localparam int         CIX_FILE_DEP  = 128;

  typedef enum logic [3:0] {
    CIX_OP_NOP    = 4'b0000,
    CIX_OP_RRC    = 4'b0001,
    CIX_OP_SUBF   = 4'b0010,
    CIX_OP_SUBL   = 4'b0011,
    CIX_OP_SUBB   = 4'b0100,
    CIX_OP_SWAP   = 4'b0101,
    CIX_OP_DIR    = 4'b0110,
    CIX_OP_XORL   = 4'b0111,
    CIX_OP_XORF   = 4'b1000,
    CIX_OP_SLEEP  = 4'b1001
  } cix_op_t;

  typedef struct packed {
    logic [7:0] k;
    logic       d;
    logic [6:0] f;
    cix_op_t    op;
  } cix_cmd_t;

  typedef struct packed {
    logic [7:0] dir_a;
    logic [7:0] dir_b;
    logic [7:0] dir_c;
  } cix_dir_t;

endpackage : cix_pkg

// ### logic/cix_exec.sv
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
// Behaviour
// - rotate file register right through carry
// - destination 0 to W, 1 to file
// - power-down: sleep, clear watchdog and prescaler
// - power-down clears power-down flag, sets timeout
// - file minus W, flags C DC Z
// - literal minus W into W, same flags
// - file minus W minus inverted carry
// - file low nibble to destination high nibble
// - W to direction register 5/6/7, no flags
// - W xor literal into W, zero only
// - W xor file to destination, zero only
module cix_exec
  import cix_pkg::*;
#(
  parameter int WDOG_PRE = CIX_WDOG_PRE,
  parameter int FILE_DEP = CIX_FILE_DEP
) (
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        arst_n_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // core state
  output cix_dir_t         dir_out,
  output logic             sleep_out,
  output logic      [7:0]  wdog_out
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]  mem_q [FILE_DEP];
  cix_cmd_t    cmd_q;
  logic        pend_q;
  logic [7:0]  w_q;
  logic        c_q, dc_q, z_q, pd_q, to_q, sleep_q;
  cix_dir_t    dir_q;
  logic [7:0]  wdog_q;
  logic [$clog2(WDOG_PRE)-1:0] pre_q;
  logic [31:0] rdata_q;
  logic        rdy_q, err_q;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  logic acc, wr_en, rd_cap, is_file, mapped;
  logic [6:0] faddr;
  assign acc     = psel_in & penable_in;
  assign wr_en   = acc & pwrite_in & rdy_q;
  assign rd_cap  = acc & ~rdy_q;
  assign is_file = (paddr_in & CIX_FILE_MASK) == CIX_FILE_BASE;
  assign faddr   = paddr_in[8:2];
  always_comb begin
    case (paddr_in)
      CIX_CMD_ADDR, CIX_ACC_ADDR, CIX_STAT_ADDR, CIX_DIRA_ADDR,
      CIX_DIRB_ADDR, CIX_DIRC_ADDR, CIX_WDOG_ADDR: mapped = 1'b1;
      default: mapped = is_file;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // execution datapath
  logic [7:0] fv, sub_a, res;
  logic       sub_ci, sub_c, sub_dc, n_c, n_dc, wr_f, wr_w, flg_z, flg_cd;
  logic [8:0] sub_s;
  logic [4:0] sub_n;
  assign fv     = mem_q[cmd_q.f];
  assign sub_a  = (cmd_q.op == CIX_OP_SUBL) ? cmd_q.k : fv;
  assign sub_ci = (cmd_q.op == CIX_OP_SUBB) ? c_q : 1'b1;
  assign sub_s  = {1'b0, sub_a} + {1'b0, ~w_q} + {8'h00, sub_ci};
  assign sub_n  = {1'b0, sub_a[3:0]} + {1'b0, ~w_q[3:0]} + {4'h0, sub_ci};
  assign sub_c  = sub_s[8];
  assign sub_dc = sub_n[4];

  always_comb begin
    res    = fv;
    n_c    = c_q;
    n_dc   = dc_q;
    wr_f   = 1'b0;
    wr_w   = 1'b0;
    flg_z  = 1'b0;
    flg_cd = 1'b0;
    case (cmd_q.op)
      CIX_OP_RRC: begin
        res  = {c_q, fv[7:1]};
        n_c  = fv[0];
        wr_f = cmd_q.d;
        wr_w = ~cmd_q.d;
      end
      CIX_OP_SUBF, CIX_OP_SUBB: begin
        res    = sub_s[7:0];
        n_c    = sub_c;
        n_dc   = sub_dc;
        flg_z  = 1'b1;
        flg_cd = 1'b1;
        wr_f   = cmd_q.d;
        wr_w   = ~cmd_q.d;
      end
      CIX_OP_SUBL: begin
        res    = sub_s[7:0];
        n_c    = sub_c;
        n_dc   = sub_dc;
        flg_z  = 1'b1;
        flg_cd = 1'b1;
        wr_w   = 1'b1;
      end
      CIX_OP_SWAP: begin
        res  = {fv[3:0], fv[7:4]};
        wr_f = cmd_q.d;
        wr_w = ~cmd_q.d;
      end
      CIX_OP_XORL: begin
        res   = w_q ^ cmd_q.k;
        flg_z = 1'b1;
        wr_w  = 1'b1;
      end
      CIX_OP_XORF: begin
        res   = w_q ^ fv;
        flg_z = 1'b1;
        wr_f  = cmd_q.d;
        wr_w  = ~cmd_q.d;
      end
      default: res = fv;
    endcase
  end

  logic ex;
  assign ex = pend_q;

  ////////////////////////////////////////////////////////////////////////////
  // file registers, execution has priority
  always_ff @(posedge mclk_in) begin
    if (ex && wr_f) begin
      mem_q[cmd_q.f] <= res;
    end else if (wr_en && is_file) begin
      mem_q[faddr] <= pwdata_in[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command latch
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cmd_q  <= '0;
      pend_q <= 1'b0;
    end else begin
      pend_q <= wr_en && (paddr_in == CIX_CMD_ADDR);
      if (wr_en && (paddr_in == CIX_CMD_ADDR)) begin
        cmd_q <= cix_cmd_t'(pwdata_in[19:0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // working register
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      w_q <= 8'h00;
    end else if (ex && wr_w) begin
      w_q <= res;
    end else if (wr_en && (paddr_in == CIX_ACC_ADDR)) begin
      w_q <= pwdata_in[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      c_q     <= 1'b0;
      dc_q    <= 1'b0;
      z_q     <= 1'b0;
      pd_q    <= 1'b1;
      to_q    <= 1'b1;
      sleep_q <= 1'b0;
    end else if (ex) begin
      c_q  <= n_c;
      dc_q <= flg_cd ? n_dc : dc_q;
      z_q  <= flg_z ? (res == 8'h00) : z_q;
      if (cmd_q.op == CIX_OP_SLEEP) begin
        pd_q    <= 1'b0;
        to_q    <= 1'b1;
        sleep_q <= 1'b1;
      end
    end else if (wr_en && (paddr_in == CIX_STAT_ADDR)) begin
      c_q  <= pwdata_in[CIX_ST_C];
      dc_q <= pwdata_in[CIX_ST_DC];
      z_q  <= pwdata_in[CIX_ST_Z];
      sleep_q <= sleep_q & pwdata_in[CIX_ST_SLEEP];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // direction registers
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dir_q <= {CIX_DIR_RST, CIX_DIR_RST, CIX_DIR_RST};
    end else if (ex && cmd_q.op == CIX_OP_DIR) begin
      case (cmd_q.f)
        CIX_DIR_SEL_A: dir_q.dir_a <= w_q;
        CIX_DIR_SEL_B: dir_q.dir_b <= w_q;
        CIX_DIR_SEL_C: dir_q.dir_c <= w_q;
        default:       dir_q       <= dir_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog counter and prescaler
  logic pre_tick;
  assign pre_tick = (pre_q == ($clog2(WDOG_PRE))'(WDOG_PRE - 1));
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pre_q  <= '0;
      wdog_q <= CIX_WDOG_ZERO;
    end else if (ex && cmd_q.op == CIX_OP_SLEEP) begin
      pre_q  <= '0;
      wdog_q <= CIX_WDOG_ZERO;
    end else begin
      pre_q  <= pre_tick ? '0 : pre_q + 1'b1;
      wdog_q <= pre_tick ? wdog_q + 8'h01 : wdog_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb read and answer, one wait state
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    case (paddr_in)
      CIX_CMD_ADDR:  rmux = {12'h000, cmd_q};
      CIX_ACC_ADDR:  rmux = {24'h000000, w_q};
      CIX_STAT_ADDR: rmux = {25'h0, pend_q, sleep_q, to_q, pd_q, z_q, dc_q,
                             c_q};
      CIX_DIRA_ADDR: rmux = {24'h000000, dir_q.dir_a};
      CIX_DIRB_ADDR: rmux = {24'h000000, dir_q.dir_b};
      CIX_DIRC_ADDR: rmux = {24'h000000, dir_q.dir_c};
      CIX_WDOG_ADDR: rmux = {24'h000000, wdog_q};
      default:       rmux = is_file ? {24'h000000, mem_q[faddr]}
                                    : 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdy_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      rdy_q <= rd_cap;
      if (rd_cap) begin
        err_q   <= ~mapped;
        rdata_q <= (pwrite_in || !mapped) ? 32'h0000_0000 : rmux;
      end
    end
  end

  assign prdata_out  = rdata_q;
  assign pready_out  = rdy_q;
  assign pslverr_out = rdy_q & err_q;
  assign dir_out     = dir_q;
  assign sleep_out   = sleep_q;
  assign wdog_out    = wdog_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic is_rrc, is_subf, is_subl, is_subb, is_swap, is_dir, is_xl, is_xf;
  assign is_rrc  = ex && cmd_q.op == CIX_OP_RRC;
  assign is_subf = ex && cmd_q.op == CIX_OP_SUBF;
  assign is_subl = ex && cmd_q.op == CIX_OP_SUBL;
  assign is_subb = ex && cmd_q.op == CIX_OP_SUBB;
  assign is_swap = ex && cmd_q.op == CIX_OP_SWAP;
  assign is_dir  = ex && cmd_q.op == CIX_OP_DIR;
  assign is_xl   = ex && cmd_q.op == CIX_OP_XORL;
  assign is_xf   = ex && cmd_q.op == CIX_OP_XORF;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  rrc_rot_a: assert property (is_rrc && !cmd_q.d |=>
    w_q[6:0] == $past(fv[7:1]))
    else $error("rotate result wrong");
  rrc_carry_a: assert property (is_rrc |=>
    c_q == $past(fv[0]) && dc_q == $past(dc_q) && z_q == $past(z_q))
    else $error("rotate carry wrong");
  dest_file_a: assert property (is_xf && cmd_q.d |=>
    w_q == $past(w_q) && fv == ($past(w_q) ^ $past(fv)))
    else $error("file destination wrong");
  sleep_wdog_a: assert property (ex && cmd_q.op == CIX_OP_SLEEP |=>
    sleep_out && wdog_out == CIX_WDOG_ZERO && pre_q == '0)
    else $error("sleep did not clear watchdog");
  sleep_flags_a: assert property (ex && cmd_q.op == CIX_OP_SLEEP |=>
    !pd_q && to_q && c_q == $past(c_q) && z_q == $past(z_q))
    else $error("sleep flags wrong");
  subf_carry_a: assert property (is_subf && !cmd_q.d |=>
    c_q == ($past(w_q) <= $past(fv)) && w_q == ($past(fv) - $past(w_q))
    && dc_q == ($past(w_q[3:0]) <= $past(fv[3:0])))
    else $error("file subtract wrong");
  subl_res_a: assert property (is_subl |=>
    w_q == ($past(cmd_q.k) - $past(w_q))
    && c_q == ($past(w_q) <= $past(cmd_q.k)) && z_q == (w_q == 8'h00))
    else $error("literal subtract wrong");
  subb_res_a: assert property (is_subb && !cmd_q.d |=>
    w_q == ($past(fv) - $past(w_q) - {7'h00, ~$past(c_q)}))
    else $error("borrow subtract wrong");
  swap_hi_a: assert property (is_swap && !cmd_q.d |=>
    w_q[7:4] == $past(fv[3:0]))
    else $error("swap high nibble wrong");
  swap_lo_a: assert property (is_swap && !cmd_q.d |=>
    w_q[3:0] == $past(fv[7:4]))
    else $error("swap low nibble wrong");
  dir_load_a: assert property (is_dir && cmd_q.f == CIX_DIR_SEL_B |=>
    dir_q.dir_b == $past(w_q) && dir_q.dir_a == $past(dir_q.dir_a)
    && c_q == $past(c_q) && z_q == $past(z_q))
    else $error("direction load wrong");
  xorl_res_a: assert property (is_xl |=>
    w_q == ($past(w_q) ^ $past(cmd_q.k)) && c_q == $past(c_q)
    && dc_q == $past(dc_q))
    else $error("literal xor wrong");
  xorf_zero_a: assert property (is_xf && !cmd_q.d |=>
    w_q == ($past(w_q) ^ $past(fv)) && z_q == (w_q == 8'h00)
    && c_q == $past(c_q))
    else $error("file xor wrong");

  sub_borrow_c: cover property (is_subb && !c_q);
  sleep_seen_c: cover property (ex && cmd_q.op == CIX_OP_SLEEP);
  rrc_file_c:   cover property (is_rrc && cmd_q.d);
  bad_addr_c:   cover property (pslverr_out);

endmodule : cix_exec

// ### sim/tb_core_instruction_subset_exec.sv
`timescale 1ns/1ps
module tb_core_instruction_subset_exec;
  import cix_pkg::*;
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  mismatches++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
  logic        mclk_in   = 1'b0;
  logic        arst_n_in = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [11:0] paddr     = 12'h000;
  logic [31:0] pwdata    = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        last_err;
  cix_dir_t    dir_out;
  logic        sleep_out;
  logic [7:0]  wdog_out;
  int          mismatches = 0;
  int          n_compared = 0;
  int          cyc        = 0;
  cix_exec #(.WDOG_PRE(2), .FILE_DEP(128)) cix_exec_i (
    .mclk_in(mclk_in), .arst_n_in(arst_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .dir_out(dir_out), .sleep_out(sleep_out),
    .wdog_out(wdog_out));
  always #10 mclk_in = ~mclk_in;
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      wrap_up();
    end
  end
  // one apb transfer, waits for pready
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    @(posedge mclk_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    do begin
      @(posedge mclk_in);
    end while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    `CHK("reg", {24'h0, e}, r)
  endtask : rchk
  function automatic logic [11:0] fa(input logic [6:0] n);
    return CIX_FILE_BASE + {3'h0, n, 2'b00};
  endfunction : fa
  // status bits 4:0 are timeout, power-down, zero, half carry, carry
  task automatic st(input logic [4:0] e);
    logic [31:0] r;
    xfer(1'b0, CIX_STAT_ADDR, 32'h0, r);
    `CHK("status", e, r[4:0])
  endtask : st
  task automatic ex(input cix_op_t op, input logic [6:0] f, input logic d,
                    input logic [7:0] k);
    cix_cmd_t c;
    c = '{k: k, d: d, f: f, op: op};
    wr(CIX_CMD_ADDR, {12'h000, c});
  endtask : ex
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] r;
    `CHK("dir", 24'hffffff, dir_out)
    `CHK("wdog", CIX_WDOG_ZERO, wdog_out)
    st(5'b11000);
    xfer(1'b0, 12'hffc, 32'h0, r);
    `CHK("slverr", 1'b1, last_err)
    `CHK("unmapped", 32'h0, r)
    $display("test reset done");
  endtask : t_reset
  task automatic t_rotate;
    wr(fa(3), 32'he6);
    wr(CIX_STAT_ADDR, 32'h1);
    ex(CIX_OP_RRC, 7'd3, 1'b0, 8'h00);
    rchk(CIX_ACC_ADDR, 8'hf3);
    rchk(fa(3), 8'he6);
    st(5'b11000);
    wr(fa(127), 32'h01);
    ex(CIX_OP_RRC, 7'd127, 1'b1, 8'h00);
    rchk(fa(127), 8'h00);
    st(5'b11001);
    $display("test rotate done");
  endtask : t_rotate
  task automatic t_sub;
    wr(fa(9), 32'h35);
    wr(CIX_ACC_ADDR, 32'h12);
    ex(CIX_OP_SUBF, 7'd9, 1'b1, 8'h00);
    rchk(fa(9), 8'h23);
    st(5'b11011);
    wr(CIX_ACC_ADDR, 32'h36);
    ex(CIX_OP_SUBF, 7'd9, 1'b0, 8'h00);
    rchk(CIX_ACC_ADDR, 8'hed);
    rchk(fa(9), 8'h23);
    st(5'b11000);
    wr(CIX_ACC_ADDR, 32'h40);
    ex(CIX_OP_SUBL, 7'd0, 1'b0, 8'h40);
    rchk(CIX_ACC_ADDR, 8'h00);
    st(5'b11111);
    ex(CIX_OP_SUBL, 7'd0, 1'b0, 8'hff);
    rchk(CIX_ACC_ADDR, 8'hff);
    st(5'b11011);
    $display("test subtract done");
  endtask : t_sub
  task automatic t_borrow;
    wr(CIX_STAT_ADDR, 32'h0);
    wr(fa(10), 32'h10);
    wr(CIX_ACC_ADDR, 32'h05);
    ex(CIX_OP_SUBB, 7'd10, 1'b1, 8'h00);
    rchk(fa(10), 8'h0a);
    st(5'b11001);
    wr(CIX_ACC_ADDR, 32'h0a);
    ex(CIX_OP_SUBB, 7'd10, 1'b0, 8'h00);
    rchk(CIX_ACC_ADDR, 8'h00);
    st(5'b11111);
    $display("test borrow done");
  endtask : t_borrow
  task automatic t_swap;
    wr(CIX_STAT_ADDR, 32'h5);
    wr(fa(127), 32'ha5);
    ex(CIX_OP_SWAP, 7'd127, 1'b0, 8'h00);
    rchk(CIX_ACC_ADDR, 8'h5a);
    ex(CIX_OP_SWAP, 7'd127, 1'b1, 8'h00);
    rchk(fa(127), 8'h5a);
    st(5'b11101);
    $display("test swap done");
  endtask : t_swap
  task automatic t_dir;
    wr(CIX_STAT_ADDR, 32'h2);
    for (int i = 0; i < 3; i++) begin
      wr(CIX_ACC_ADDR, 32'h11 * (i + 1));
      ex(CIX_OP_DIR, CIX_DIR_SEL_A + 7'(i), 1'b0, 8'h00);
    end
    // last load runs one edge after its command write
    repeat (2) @(posedge mclk_in);
    `CHK("dir", 24'h112233, dir_out)
    rchk(CIX_DIRB_ADDR, 8'h22);
    st(5'b11010);
    $display("test direction done");
  endtask : t_dir
  task automatic t_xor;
    wr(CIX_STAT_ADDR, 32'h1);
    wr(CIX_ACC_ADDR, 32'h5a);
    ex(CIX_OP_XORL, 7'd0, 1'b0, 8'h5a);
    rchk(CIX_ACC_ADDR, 8'h00);
    st(5'b11101);
    ex(CIX_OP_XORL, 7'd0, 1'b0, 8'hff);
    st(5'b11001);
    wr(fa(0), 32'hff);
    ex(CIX_OP_XORF, 7'd0, 1'b1, 8'h00);
    rchk(fa(0), 8'h00);
    rchk(CIX_ACC_ADDR, 8'hff);
    st(5'b11101);
    $display("test xor done");
  endtask : t_xor
  task automatic t_sleep;
    logic [31:0] r;
    wr(CIX_STAT_ADDR, 32'h7);
    ex(CIX_OP_SLEEP, 7'd0, 1'b0, 8'h00);
    @(posedge mclk_in);
    @(posedge mclk_in);
    `CHK("wdog", CIX_WDOG_ZERO, wdog_out)
    `CHK("sleep", 1'b1, sleep_out)
    // prescale of 2: counter restarts from zero, two ticks in four edges
    repeat (4) @(posedge mclk_in);
    `CHK("wdog count", 8'h02, wdog_out)
    st(5'b10111);
    xfer(1'b0, CIX_STAT_ADDR, 32'h0, r);
    `CHK("sleep bit", 1'b1, r[5])
    $display("test power-down done");
  endtask : t_sleep
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    t_reset();
    t_rotate();
    t_sub();
    t_borrow();
    t_swap();
    t_dir();
    t_xor();
    t_sleep();
    wrap_up();
  end
endmodule : tb_core_instruction_subset_exec
